// file: hw/modem_status_pkg.sv
// Package: register map, status bit positions, task codes and datapath event struct
package modem_status_pkg;
	localparam logic [31:0] STATUS_OFFSET = 32'h0000_0000;
	localparam logic [31:0] QUALITY_OFFSET = 32'h0000_0004;
	localparam logic [31:0] COMMAND_OFFSET = 32'h0000_0008;
	localparam logic [31:0] MODE_OFFSET = 32'h0000_000C;
	localparam int IRQ_BIT = 7;
	localparam int BUFFER_FREE_FLAG_BIT = 6;
	localparam int DRAIN_BIT = 5;
	localparam int OVF_BIT = 4;
	localparam int CRC_BIT = 3;
	localparam int SIDE_SYMBOL_READY_FLAG_BIT = 2;
	localparam int CMD_AUTO_BIT = 7;
	localparam int MODE_TX_BIT = 0;
	localparam int MODE_ZP_BIT = 1;
	localparam int MODE_PS_BIT = 2;
	localparam int MODE_FOUR_BIT = 3;
	localparam logic [7:0] STATUS_RESET = 8'h60;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [2:0] QUALITY_ZERO = 3'h0;
	localparam logic [1:0] SIDE_ZERO = 2'h0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
	localparam logic [6:0] TASK_NULL = 7'h00;
	localparam logic [6:0] TASK_RESET = 7'h07;
	localparam logic [6:0] TASK_PREAMBLE = 7'h05;
	localparam logic [6:0] TASK_SEARCH = 7'h04;
	localparam logic [6:0] TASK_HEADER = 7'h02;
	localparam logic [6:0] TASK_LATER = 7'h03;
	localparam logic [6:0] TASK_STATION = 7'h06;
	localparam logic [6:0] TASK_BYTE = 7'h08;
	localparam logic [6:0] TASK_FOUR = 7'h01;
	localparam logic [15:0] SYMBOL_DIV = 16'h0009;
	localparam logic [1:0] MID_LEVEL = 2'h2;

	// Events reported by the task datapath, one-cycle pulses
	typedef struct packed {
		logic task_done;
		logic checksum_fail;
		logic drained;
		logic sync_found;
		logic late_task;
		logic side_event;
		logic side_last;
		logic [1:0] side_value;
		logic sync_inverse;
	} dp_event_t;
endpackage : modem_status_pkg

// file: hw/modem_status_and_sync_flags.sv
// Status flags, quality register and autonomous sync handling of the modem host interface
//
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module modem_status_and_sync_flags (
	input wire logic REF_CLK,
	input wire logic RSTN,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire modem_status_pkg::dp_event_t DP_EVENT,
	input wire logic [4:0] QUALITY_MEASURE,
	input wire logic DP_BUFFER_EMPTY,
	output logic [6:0] TASK_CODE,
	output logic TASK_STROBE,
	output logic TASK_ABORT,
	output logic RETRAIN,
	output logic HOLD_TRAINING,
	output logic AUTO_SEARCH_EN,
	output logic MID_LEVEL_FEED,
	output logic [1:0] FILTER_LEVEL_SEL,
	output logic [7:0] MODE_BITS
);
	logic ph_valid_r;
	logic ph_write_r;
	logic [31:0] ph_addr_r;
	logic [7:0] status_r;
	logic [7:0] mode_r;
	logic [7:0] command_r;
	logic [4:0] quality_r;
	logic [15:0] sym_cnt_r;
	logic drain_clear_pend_r;
	logic [6:0] task_r;
	logic task_strobe_r;
	logic abort_r;
	logic retrain_r;
	logic hold_r;
	logic mid_r;
	logic [31:0] hrdata_r;
	logic irq_r;
	logic buffer_free_flag_r;
	logic drain_r;
	logic ovf_r;
	logic crc_r;
	logic side_symbol_ready_flag_r;
	logic [1:0] side_r;
	logic [1:0] filter_r;

	logic addr_take;
	logic wr_cmd;
	logic wr_mode;
	logic rd_status;
	logic real_task;
	logic reset_task;
	logic mode_change;
	logic quiet_set;
	logic tx_mode;
	logic four_level;
	logic auto_en;
	logic auto_hit;
	logic sym_tick;
	logic buffer_free_flag_rise;
	logic drain_rise;
	logic late_ok;
	logic crc_task;
	logic search_task;
	logic side_ok;
	logic rd_rx_clear;
	logic [7:0] hwdata_b;

	assign addr_take = HSEL && HREADY && HTRANS == modem_status_pkg::HTRANS_NONSEQ;
	assign hwdata_b = HWDATA[7:0];
	assign wr_cmd = ph_valid_r && ph_write_r && ph_addr_r == modem_status_pkg::COMMAND_OFFSET;
	assign wr_mode = ph_valid_r && ph_write_r && ph_addr_r == modem_status_pkg::MODE_OFFSET;
	assign rd_status = ph_valid_r && !ph_write_r && ph_addr_r == modem_status_pkg::STATUS_OFFSET;
	assign reset_task = wr_cmd && hwdata_b[6:0] == modem_status_pkg::TASK_RESET;
	assign real_task = wr_cmd && hwdata_b[6:0] != modem_status_pkg::TASK_RESET
		&& hwdata_b[6:0] != modem_status_pkg::TASK_NULL;
	assign mode_change = wr_mode && (hwdata_b[modem_status_pkg::MODE_TX_BIT] != mode_r[modem_status_pkg::MODE_TX_BIT]
		|| hwdata_b[modem_status_pkg::MODE_ZP_BIT] != mode_r[modem_status_pkg::MODE_ZP_BIT]
		|| hwdata_b[modem_status_pkg::MODE_PS_BIT] != mode_r[modem_status_pkg::MODE_PS_BIT]);
	assign quiet_set = reset_task || mode_change;
	assign tx_mode = mode_r[modem_status_pkg::MODE_TX_BIT];
	assign four_level = mode_r[modem_status_pkg::MODE_FOUR_BIT];
	assign auto_en = command_r[modem_status_pkg::CMD_AUTO_BIT];
	// Preamble search in four-level mode reports its own sync through buffer-free
	assign auto_hit = !tx_mode && auto_en && DP_EVENT.sync_found
		&& !(four_level && task_r == modem_status_pkg::TASK_PREAMBLE);
	assign sym_tick = sym_cnt_r == modem_status_pkg::SYMBOL_DIV;
	assign rd_rx_clear = rd_status && !tx_mode;
	assign buffer_free_flag_rise = DP_EVENT.task_done && !buffer_free_flag_r;
	assign drain_rise = tx_mode && DP_EVENT.drained && !drain_r;
	assign side_ok = DP_EVENT.side_event && !DP_EVENT.side_last;
	// Only tasks whose blocks carry a checksum update the error flag
	assign crc_task = task_r == modem_status_pkg::TASK_PREAMBLE
		|| task_r == modem_status_pkg::TASK_HEADER
		|| task_r == modem_status_pkg::TASK_LATER
		|| task_r == modem_status_pkg::TASK_STATION;
	assign late_ok = !tx_mode && DP_EVENT.late_task && (task_r == modem_status_pkg::TASK_HEADER
		|| task_r == modem_status_pkg::TASK_LATER
		|| task_r == modem_status_pkg::TASK_STATION
		|| task_r == modem_status_pkg::TASK_BYTE
		|| task_r == modem_status_pkg::TASK_FOUR);
	assign search_task = task_r == modem_status_pkg::TASK_SEARCH
		|| task_r == modem_status_pkg::TASK_PREAMBLE;

	// Zero wait state slave: address phase captured, data phase acts
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			ph_valid_r <= 1'b0;
			ph_write_r <= 1'b0;
			ph_addr_r <= 32'h0000_0000;
		end else begin
			ph_valid_r <= addr_take && HSIZE == modem_status_pkg::HSIZE_WORD;
			ph_write_r <= HWRITE;
			ph_addr_r <= HADDR;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end else begin
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end
	end

	// Read data is captured in the address phase so a status read sees pre-clear flags
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			hrdata_r <= modem_status_pkg::UNMAPPED_DATA;
		end else begin
			if (addr_take && !HWRITE) begin
				unique case (HADDR)
					modem_status_pkg::STATUS_OFFSET: hrdata_r <= {24'h000000, status_r};
					modem_status_pkg::QUALITY_OFFSET: hrdata_r <= {24'h000000, quality_r, modem_status_pkg::QUALITY_ZERO};
					modem_status_pkg::COMMAND_OFFSET: hrdata_r <= {24'h000000, command_r};
					modem_status_pkg::MODE_OFFSET: hrdata_r <= {24'h000000, mode_r};
					default: hrdata_r <= modem_status_pkg::UNMAPPED_DATA;
				endcase
			end
		end
	end
	assign HRDATA = hrdata_r;

	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			mode_r <= modem_status_pkg::MODE_RESET;
		end else if (wr_mode) begin
			mode_r <= hwdata_b;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			command_r <= 8'h00;
		end else if (wr_cmd) begin
			command_r <= hwdata_b;
		end
	end

	// Receive quality tracks the measurement; host must wait for lock itself
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			quality_r <= 5'h00;
		end else if (!tx_mode) begin
			quality_r <= QUALITY_MEASURE;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			sym_cnt_r <= 16'h0000;
		end else if (sym_tick) begin
			sym_cnt_r <= 16'h0000;
		end else begin
			sym_cnt_r <= sym_cnt_r + 16'h0001;
		end
	end

	// Drained clear waits for the next symbol boundary, at most one symbol later
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			drain_clear_pend_r <= 1'b0;
		end else if (quiet_set || !tx_mode) begin
			drain_clear_pend_r <= 1'b0;
		end else if (real_task) begin
			drain_clear_pend_r <= 1'b1;
		end else if (sym_tick) begin
			drain_clear_pend_r <= 1'b0;
		end
	end

	// Priority per flag: quiet set (none on irq), then hardware set, then read clear, so no event is lost to a read
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			irq_r <= modem_status_pkg::STATUS_RESET[modem_status_pkg::IRQ_BIT];
		end else if (buffer_free_flag_rise || drain_rise || auto_hit || late_ok) begin
			irq_r <= 1'b1;
		end else if (rd_status) begin
			irq_r <= 1'b0;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			buffer_free_flag_r <= modem_status_pkg::STATUS_RESET[modem_status_pkg::BUFFER_FREE_FLAG_BIT];
		end else if (quiet_set) begin
			buffer_free_flag_r <= 1'b1;
		end else if (buffer_free_flag_rise) begin
			buffer_free_flag_r <= 1'b1;
		end else if (real_task) begin
			buffer_free_flag_r <= 1'b0;
		end
	end

	// Quiet set follows the direction in force before the write
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			drain_r <= modem_status_pkg::STATUS_RESET[modem_status_pkg::DRAIN_BIT];
		end else if (quiet_set) begin
			drain_r <= tx_mode;
		end else if (drain_rise || auto_hit) begin
			drain_r <= 1'b1;
		end else if (drain_clear_pend_r && sym_tick) begin
			drain_r <= 1'b0;
		end else if (rd_rx_clear) begin
			drain_r <= 1'b0;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			ovf_r <= modem_status_pkg::STATUS_RESET[modem_status_pkg::OVF_BIT];
		end else if (quiet_set || tx_mode) begin
			ovf_r <= 1'b0;
		end else if (late_ok) begin
			ovf_r <= 1'b1;
		end else if (rd_status) begin
			ovf_r <= 1'b0;
		end
	end

	// A read leaves the checksum flag; it stands until the next result
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			crc_r <= modem_status_pkg::STATUS_RESET[modem_status_pkg::CRC_BIT];
		end else if (quiet_set || tx_mode) begin
			crc_r <= 1'b0;
		end else if (buffer_free_flag_rise && crc_task) begin
			crc_r <= DP_EVENT.checksum_fail;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			side_symbol_ready_flag_r <= modem_status_pkg::STATUS_RESET[modem_status_pkg::SIDE_SYMBOL_READY_FLAG_BIT];
		end else if (quiet_set) begin
			side_symbol_ready_flag_r <= 1'b0;
		end else if (side_ok) begin
			side_symbol_ready_flag_r <= 1'b1;
		end else if (rd_status) begin
			side_symbol_ready_flag_r <= 1'b0;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			side_r <= modem_status_pkg::STATUS_RESET[1:0];
		end else if (tx_mode) begin
			side_r <= modem_status_pkg::SIDE_ZERO;
		end else begin
			if (side_ok) begin
				side_r[0] <= DP_EVENT.side_value[0];
			end
			if (side_ok && four_level) begin
				side_r[1] <= DP_EVENT.side_value[1];
			end else if (!four_level && DP_EVENT.sync_found) begin
				side_r[1] <= DP_EVENT.sync_inverse;
			end
		end
	end

	assign status_r = {irq_r, buffer_free_flag_r, drain_r, ovf_r, crc_r, side_symbol_ready_flag_r, side_r};

	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			task_r <= modem_status_pkg::TASK_NULL;
		end else if (wr_cmd) begin
			task_r <= hwdata_b[6:0];
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			task_strobe_r <= 1'b0;
		end else begin
			task_strobe_r <= wr_cmd;
		end
	end

	// Abort and retrain pulse together on an accepted autonomous hit
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			abort_r <= 1'b0;
			retrain_r <= 1'b0;
		end else begin
			abort_r <= auto_hit;
			retrain_r <= auto_hit;
		end
	end

	// Search tasks reuse existing timing and levels
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			hold_r <= 1'b0;
		end else begin
			hold_r <= !tx_mode && search_task && !auto_hit;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			mid_r <= 1'b0;
			filter_r <= 2'h0;
		end else begin
			mid_r <= tx_mode && DP_BUFFER_EMPTY;
			filter_r <= (tx_mode && DP_BUFFER_EMPTY) ? modem_status_pkg::MID_LEVEL : 2'h0;
		end
	end

	assign TASK_CODE = task_r;
	assign TASK_STROBE = task_strobe_r;
	assign TASK_ABORT = abort_r;
	assign RETRAIN = retrain_r;
	assign HOLD_TRAINING = hold_r;
	assign AUTO_SEARCH_EN = command_r[modem_status_pkg::CMD_AUTO_BIT];
	assign MID_LEVEL_FEED = mid_r;
	assign FILTER_LEVEL_SEL = filter_r;
	assign MODE_BITS = mode_r;
endmodule : modem_status_and_sync_flags
`default_nettype wire

// file: testbench/dp_model.sv
// Datapath stand-in: event pulses, quality level, buffer empty level
`timescale 1ns/1ps
`default_nettype none
module dp_model (
	input wire logic REF_CLK,
	output var modem_status_pkg::dp_event_t DP_EVENT,
	output var logic [4:0] QUALITY_MEASURE,
	output var logic DP_BUFFER_EMPTY
);
	initial begin
		DP_EVENT = '0;
		QUALITY_MEASURE = 5'h00;
		DP_BUFFER_EMPTY = 1'b0;
	end
	// One cycle only, since every pulse counts as an event
	task automatic pulse(input logic [9:0] e);
		DP_EVENT <= e;
		@(posedge REF_CLK);
		DP_EVENT <= '0;
		@(posedge REF_CLK);
	endtask : pulse
	task automatic levels(input logic [4:0] q, input logic b);
		QUALITY_MEASURE <= q;
		DP_BUFFER_EMPTY <= b;
	endtask : levels
endmodule : dp_model
`default_nettype wire

// file: testbench/modem_status_and_sync_flags_sva.sv
// Port-level checks of the status and sync flag block
`timescale 1ns/1ps
`default_nettype none
module modem_status_and_sync_flags_sva (
	input wire logic REF_CLK,
	input wire logic RSTN,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	input wire modem_status_pkg::dp_event_t DP_EVENT,
	input wire logic DP_BUFFER_EMPTY,
	input wire logic [6:0] TASK_CODE,
	input wire logic TASK_STROBE,
	input wire logic TASK_ABORT,
	input wire logic RETRAIN,
	input wire logic AUTO_SEARCH_EN,
	input wire logic MID_LEVEL_FEED,
	input wire logic [1:0] FILTER_LEVEL_SEL,
	input wire logic [7:0] MODE_BITS
);
	logic acc, hit, wc_r, wm_r, rs_r, rq_r;
	assign acc = HSEL && HREADY && HTRANS == modem_status_pkg::HTRANS_NONSEQ && HSIZE == modem_status_pkg::HSIZE_WORD;
	// Four-level left out, so no sync in four-level mode counts as a hit
	assign hit = DP_EVENT.sync_found && AUTO_SEARCH_EN && !MODE_BITS[0] && !MODE_BITS[3];
	always_ff @(posedge REF_CLK) begin
		wc_r <= RSTN && acc && HWRITE && HADDR == modem_status_pkg::COMMAND_OFFSET;
		wm_r <= RSTN && acc && HWRITE && HADDR == modem_status_pkg::MODE_OFFSET;
		rs_r <= RSTN && acc && !HWRITE && HADDR == modem_status_pkg::STATUS_OFFSET;
		rq_r <= RSTN && acc && !HWRITE && HADDR == modem_status_pkg::QUALITY_OFFSET;
	end
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);
	property p_mid; MID_LEVEL_FEED == $past(MODE_BITS[0] && DP_BUFFER_EMPTY); endproperty
	a_mid: assert property (p_mid) else $error("mid feed wrong");
	property p_lvl; FILTER_LEVEL_SEL == (MID_LEVEL_FEED ? modem_status_pkg::MID_LEVEL : 2'h0); endproperty
	a_lvl: assert property (p_lvl) else $error("filter level wrong");
	property p_hit; hit |=> TASK_ABORT && RETRAIN; endproperty
	a_hit: assert property (p_hit) else $error("no abort on sync");
	property p_nohit; !DP_EVENT.sync_found |=> !TASK_ABORT && !RETRAIN; endproperty
	a_nohit: assert property (p_nohit) else $error("abort without sync");
	property p_stb; wc_r |=> TASK_STROBE && TASK_CODE == $past(HWDATA[6:0]) && AUTO_SEARCH_EN == $past(HWDATA[7]); endproperty
	a_stb: assert property (p_stb) else $error("command not taken");
	property p_mode; wm_r |=> MODE_BITS == $past(HWDATA[7:0]); endproperty
	a_mode: assert property (p_mode) else $error("mode not taken");
	property p_tx; rs_r && MODE_BITS[0] && $past(MODE_BITS[0]) && $past(MODE_BITS[0], 2) |-> (HRDATA & 32'hFFFFFF1B) == 32'h0; endproperty
	a_tx: assert property (p_tx) else $error("transmit status bits set");
	property p_q; rq_r |-> HRDATA[2:0] == modem_status_pkg::QUALITY_ZERO && HRDATA[31:8] == 24'h0; endproperty
	a_q: assert property (p_q) else $error("quality low bits set");
endmodule : modem_status_and_sync_flags_sva
bind modem_status_and_sync_flags modem_status_and_sync_flags_sva modem_status_and_sync_flags_sva_i (
	.REF_CLK(REF_CLK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
	.HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .DP_EVENT(DP_EVENT), .DP_BUFFER_EMPTY(DP_BUFFER_EMPTY),
	.TASK_CODE(TASK_CODE), .TASK_STROBE(TASK_STROBE), .TASK_ABORT(TASK_ABORT), .RETRAIN(RETRAIN),
	.AUTO_SEARCH_EN(AUTO_SEARCH_EN), .MID_LEVEL_FEED(MID_LEVEL_FEED), .FILTER_LEVEL_SEL(FILTER_LEVEL_SEL),
	.MODE_BITS(MODE_BITS)
);
`default_nettype wire

// file: testbench/test_modem_status_and_sync_flags.sv
// Bench: host bus traffic and datapath events checked against status
`timescale 1ns/1ps
`default_nettype none
module test_modem_status_and_sync_flags;
	localparam logic [31:0] ST = modem_status_pkg::STATUS_OFFSET;
	localparam logic [31:0] CM = modem_status_pkg::COMMAND_OFFSET;
	localparam logic [31:0] MD = modem_status_pkg::MODE_OFFSET;
	localparam logic [31:0] M = 32'hFFFFFFFF;
	localparam logic [7:0] HD = {1'b0, modem_status_pkg::TASK_HEADER};
	localparam logic [7:0] AH = {1'b1, modem_status_pkg::TASK_HEADER};
	localparam logic [7:0] RS = {1'b0, modem_status_pkg::TASK_RESET};
	localparam logic [7:0] PR = {1'b1, modem_status_pkg::TASK_PREAMBLE};
	logic REF_CLK = 1'b0, RSTN = 1'b0, HSEL = 1'b0, HWRITE = 1'b0;
	logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, r;
	logic [1:0] HTRANS = 2'h0;
	logic [2:0] HSIZE = modem_status_pkg::HSIZE_WORD;
	wire [31:0] HRDATA;
	wire hready, empty, hold, auto, mid;
	wire [1:0] fsel;
	wire [7:0] mbits;
	wire [4:0] qual;
	wire modem_status_pkg::dp_event_t ev;
	int fail_count = 0;
	int check_count = 0;
	always #10 REF_CLK = ~REF_CLK;
	dp_model dp_model_i (.REF_CLK(REF_CLK), .DP_EVENT(ev), .QUALITY_MEASURE(qual), .DP_BUFFER_EMPTY(empty));
	modem_status_and_sync_flags modem_status_and_sync_flags_i (
		.REF_CLK(REF_CLK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
		.HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(hready), .HRDATA(HRDATA), .HREADYOUT(hready), .HRESP(),
		.DP_EVENT(ev), .QUALITY_MEASURE(qual), .DP_BUFFER_EMPTY(empty), .TASK_CODE(), .TASK_STROBE(),
		.TASK_ABORT(), .RETRAIN(), .HOLD_TRAINING(hold), .AUTO_SEARCH_EN(auto), .MID_LEVEL_FEED(mid),
		.FILTER_LEVEL_SEL(fsel), .MODE_BITS(mbits)
	);
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			fail_count++;
			$display("mismatch at %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	// Each phase held until ready is seen at an edge; bounded so a hang ends the run
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		HSEL <= 1'b1;
		HADDR <= a;
		HWRITE <= w;
		HTRANS <= modem_status_pkg::HTRANS_NONSEQ;
		do @(posedge REF_CLK); while (hready !== 1'b1 && ++n < 40);
		HTRANS <= 2'h0;
		HWDATA <= d;
		do @(posedge REF_CLK); while (hready !== 1'b1 && ++n < 40);
		r = HRDATA;
		if (n >= 40) begin
			fail_count++;
			finish_test();
		end
	endtask : xfer
	task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(r & m, e);
	endtask : rd
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		xfer(1'b1, a, {24'h0, d});
	endtask : wr
	initial begin
		repeat (20) @(posedge REF_CLK);
		RSTN <= 1'b1;
		@(posedge REF_CLK);
		rd(ST, M, 32'h60);
		rd(ST, M, 32'h40);
		rd(32'h10, M, 32'h0);
		rd(MD, M, 32'h0);
		dp_model_i.levels(5'h15, 1'b0);
		repeat (640) @(posedge REF_CLK);
		rd(modem_status_pkg::QUALITY_OFFSET, M, 32'hA8);
		chk(mid, 32'h0);
		wr(CM, HD);
		rd(ST, M, 32'h0);
		chk(auto, 32'h0);
		dp_model_i.pulse(10'h300);
		rd(ST, M, 32'hC8);
		rd(ST, M, 32'h48);
		wr(CM, HD);
		dp_model_i.pulse(10'h020);
		rd(ST, M, 32'h98);
		rd(ST, M, 32'h08);
		wr(CM, RS);
		rd(ST, M, 32'h40);
		wr(MD, 8'h08);
		wr(CM, HD);
		dp_model_i.pulse(10'h016);
		rd(ST, M, 32'h07);
		rd(ST, M, 32'h03);
		dp_model_i.pulse(10'h01A);
		rd(ST, 32'h04, 32'h0);
		wr(CM, PR);
		dp_model_i.pulse(10'h040);
		rd(ST, 32'hA0, 32'h0);
		chk(hold, 32'h1);
		chk(auto, 32'h1);
		wr(MD, 8'h00);
		wr(CM, AH);
		dp_model_i.pulse(10'h041);
		rd(ST, 32'hA2, 32'hA2);
		chk(hold, 32'h0);
		rd(ST, 32'hA0, 32'h0);
		dp_model_i.pulse(10'h040);
		wr(MD, 8'h04);
		rd(ST, 32'h7C, 32'h40);
		chk(mbits, 32'h04);
		wr(MD, 8'h05);
		xfer(1'b0, ST, 32'h0);
		wr(MD, 8'h01);
		rd(ST, M, 32'h60);
		wr(CM, HD);
		repeat (10) @(posedge REF_CLK);
		rd(ST, M, 32'h0);
		dp_model_i.levels(5'h15, 1'b1);
		dp_model_i.pulse(10'h080);
		rd(ST, M, 32'hA0);
		chk(mid, 32'h1);
		chk(fsel, {30'h0, modem_status_pkg::MID_LEVEL});
		dp_model_i.pulse(10'h336);
		rd(ST, M, 32'hE4);
		rd(ST, M, 32'h60);
		finish_test();
	end
endmodule : test_modem_status_and_sync_flags
`default_nettype wire
